// ### verilog/pdr_pkg.sv
package pdr_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_KHZ = 25000;
   localparam int unsigned ZERO_MS = 250;
   localparam int unsigned STEP_MS = 20;
   localparam int unsigned RAMP_KHZ = 250;
   localparam int unsigned SOFT_STEP_US = 40;
   localparam int unsigned ZERO_CYC = ZERO_MS * CLK_KHZ;
   localparam int unsigned STEP_CYC = STEP_MS * CLK_KHZ;
   localparam int unsigned SOFT_STEP_CYC = (SOFT_STEP_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned RAMP_PERIOD = CLK_KHZ / RAMP_KHZ;
   localparam int unsigned RAMP_HALF = RAMP_PERIOD / 2;
   localparam int unsigned TIMER_W = 23;
   localparam int unsigned RC_W = 7;

   // ----------------------------------------
   // duty levels and reset values
   // ----------------------------------------
   localparam int unsigned DUTY_W = 8;
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 8'h00;
   localparam logic [DUTY_W-1:0] DUTY_LOW = 8'h60;
   localparam logic [DUTY_W-1:0] DUTY_HIGH = 8'ha0;
   localparam logic [DUTY_W-1:0] DUTY_MAX = 8'hf0;
   localparam logic [DUTY_W-1:0] DUTY_ONE = 8'h01;
   localparam logic SWITCH_OFF_N = 1'b1;
   localparam logic LED_OFF_N = 1'b1;
   localparam int unsigned SYNC_N = 3;

   // ----------------------------------------
   // port sequencer states
   // ----------------------------------------
   typedef enum logic [7:0] {
      ST_HOLD = 8'h01,
      ST_ZERO = 8'h02,
      ST_LOW1 = 8'h04,
      ST_HIGH = 8'h08,
      ST_LOW2 = 8'h10,
      ST_EVAL = 8'h20,
      ST_RAMP = 8'h40,
      ST_REG = 8'h80
   } pdr_state_e;

endpackage

// ### verilog/pdr_pwm.sv
`timescale 1ns/1ps
module pdr_pwm
   import pdr_pkg::*;
#(
   parameter int unsigned W = DUTY_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // duty request
   input wire logic [W-1:0] duty,
   // paired drive outputs
   output logic out_a,
   output logic out_b
);

   logic [W-1:0] cnt;
   logic [W-1:0] cnt_b;
   logic next_a;
   logic next_b;

   // ----------------------------------------
   // phase split
   // ----------------------------------------
   // b runs half a period behind a so the external average ripples less
   assign cnt_b = cnt ^ {1'b1, {(W-1){1'b0}}};
   assign next_a = (cnt < duty);
   assign next_b = (cnt_b < duty);

   // free running period counter and drive flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
         out_a <= 1'b0;
         out_b <= 1'b0;
      end else begin
         cnt <= cnt + 1'b1;
         out_a <= next_a;
         out_b <= next_b;
      end
   end

endmodule // pdr_pwm

// ### verilog/pdr_top.sv
`timescale 1ns/1ps
module pdr_top
   import pdr_pkg::*;
#(
   parameter int unsigned ZERO_CYCLES = ZERO_CYC,
   parameter int unsigned STEP_CYCLES = STEP_CYC,
   parameter int unsigned SOFT_CYCLES = SOFT_STEP_CYC
) (
   // clock and system reset
   input wire logic clk,
   input wire logic rst,
   // pins from the board
   input wire logic port_reset_n,
   input wire logic valid_signature_window,
   input wire logic output_voltage_sense,
   // drive pins
   output logic switch_ctrl_n,
   output logic duty_drive_a,
   output logic duty_drive_b,
   output logic switcher_ramp_clock,
   output logic led_n
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [SYNC_N-1:0] pin_raw;
   logic [SYNC_N-1:0] pin_meta;
   logic [SYNC_N-1:0] pin_sync;
   logic reset_pin_up;
   logic window_ok;
   logic above_set;

   assign pin_raw = {output_voltage_sense, valid_signature_window, port_reset_n};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
         // two flops per pin; the first is read only by the second
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               pin_meta[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_sync[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   assign reset_pin_up = pin_sync[0];
   assign window_ok = pin_sync[1];
   assign above_set = pin_sync[2];

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   pdr_state_e state;
   pdr_state_e next_state;
   logic [TIMER_W-1:0] timer;
   logic [TIMER_W-1:0] next_timer;
   logic [TIMER_W-1:0] load_val;
   logic timer_done;
   logic sig_ok;
   logic next_sig_ok;
   logic power_on;
   logic next_power;
   logic step_end;
   logic [DUTY_W-1:0] duty;
   logic [DUTY_W-1:0] next_duty;
   logic [DUTY_W-1:0] duty_up;
   logic [DUTY_W-1:0] duty_dn;
   logic [DUTY_W-1:0] duty_adj;

   assign timer_done = (timer == '0);
   assign power_on = (state == ST_RAMP) || (state == ST_REG);
   assign next_power = (next_state == ST_RAMP) || (next_state == ST_REG);
   assign step_end = timer_done &&
      ((state == ST_LOW1) || (state == ST_HIGH) || (state == ST_LOW2));

   // next state; a low reset pin overrides everything
   always_comb begin
      next_state = state;
      unique case (state)
         ST_HOLD: next_state = ST_ZERO;
         ST_ZERO: if (timer_done) next_state = ST_LOW1;
         ST_LOW1: if (timer_done) next_state = ST_HIGH;
         ST_HIGH: if (timer_done) next_state = ST_LOW2;
         ST_LOW2: if (timer_done) next_state = ST_EVAL;
         ST_EVAL: next_state = sig_ok ? ST_RAMP : ST_ZERO;
         ST_RAMP: if (timer_done && above_set) next_state = ST_REG;
         ST_REG: next_state = ST_REG;
      endcase
      if (!reset_pin_up) begin
         next_state = ST_HOLD;
      end
   end

   // dwell loaded on entry; power states reload every soft step
   always_comb begin
      unique case (next_state)
         ST_ZERO: load_val = TIMER_W'(ZERO_CYCLES - 1);
         ST_LOW1, ST_HIGH, ST_LOW2: load_val = TIMER_W'(STEP_CYCLES - 1);
         ST_RAMP, ST_REG: load_val = TIMER_W'(SOFT_CYCLES - 1);
         default: load_val = '0;
      endcase
   end

   assign next_timer = ((next_state != state) || (timer_done && power_on)) ? load_val :
      (timer_done ? timer : timer - 1'b1);

   // three point check: window must hold at the end of every step
   assign next_sig_ok = (state == ST_ZERO) ? 1'b1 :
      (step_end ? (sig_ok && window_ok) : sig_ok);

   // soft start climbs one count per step; regulation trims by feedback
   assign duty_up = (duty < DUTY_MAX) ? duty + DUTY_ONE : duty;
   assign duty_dn = (duty > DUTY_ZERO) ? duty - DUTY_ONE : duty;
   assign duty_adj = !timer_done ? duty :
      (above_set ? ((state == ST_REG) ? duty_dn : duty) : duty_up);

   always_comb begin
      unique case (next_state)
         ST_LOW1, ST_LOW2: next_duty = DUTY_LOW;
         ST_HIGH: next_duty = DUTY_HIGH;
         ST_RAMP: next_duty = power_on ? duty_adj : DUTY_ZERO;
         ST_REG: next_duty = duty_adj;
         default: next_duty = DUTY_ZERO;
      endcase
   end

   // state, timer and duty flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_HOLD;
         timer <= '0;
         sig_ok <= 1'b0;
         duty <= DUTY_ZERO;
      end else begin
         state <= next_state;
         timer <= next_timer;
         sig_ok <= next_sig_ok;
         duty <= next_duty;
      end
   end

   // ----------------------------------------
   // duty pair
   // ----------------------------------------
   pdr_pwm #(
      .W(DUTY_W)
   ) u_pwm (
      .clk(clk),
      .rst(rst),
      .duty(duty),
      .out_a(duty_drive_a),
      .out_b(duty_drive_b)
   );

   // ----------------------------------------
   // ramp clock, switch and indicator
   // ----------------------------------------
   logic [RC_W-1:0] rc_cnt;
   logic [RC_W-1:0] next_rc_cnt;
   logic next_led_lit;

   // counter restarts on every enable so the first high phase is whole
   assign next_rc_cnt = (!power_on || (rc_cnt == RC_W'(RAMP_PERIOD - 1))) ? '0 :
      rc_cnt + 1'b1;
   // led flashes once per detection pass and is steady when powered
   assign next_led_lit = next_power || (next_state == ST_LOW1) ||
      (next_state == ST_HIGH) || (next_state == ST_LOW2);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rc_cnt <= '0;
         switcher_ramp_clock <= 1'b0;
         switch_ctrl_n <= SWITCH_OFF_N;
         led_n <= LED_OFF_N;
      end else begin
         rc_cnt <= next_rc_cnt;
         switcher_ramp_clock <= next_power && (next_rc_cnt < RC_W'(RAMP_HALF));
         switch_ctrl_n <= !next_power;
         led_n <= !next_led_lit;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [RC_W-1:0] hi_cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hi_cnt <= '0;
      end else begin
         hi_cnt <= switcher_ramp_clock ? hi_cnt + 1'b1 : '0;
      end
   end

   a_hold_inactive: assert property (!reset_pin_up |=> switch_ctrl_n && !switcher_ramp_clock
      && duty == DUTY_ZERO) else $error("port active under reset pin");
   a_switch_matches: assert property (switch_ctrl_n == !power_on)
      else $error("switch pin disagrees with power state");
   a_ramp_gated: assert property (!power_on |-> !switcher_ramp_clock)
      else $error("ramp clock toggles while off");
   a_ramp_half: assert property ($fell(switcher_ramp_clock) && power_on
      |-> hi_cnt == RC_W'(RAMP_HALF)) else $error("ramp clock high phase wrong");
   a_detect_start: assert property ($rose(reset_pin_up) |=> state == ST_ZERO ##1
      state == ST_ZERO) else $error("detection not started on release");
   a_power_valid: assert property ($rose(power_on) |-> $past(state) == ST_EVAL
      && $past(sig_ok)) else $error("power without valid signature");
   a_step_levels: assert property ((state == ST_HIGH |-> duty == DUTY_HIGH) and
      (state == ST_ZERO |-> duty == DUTY_ZERO)) else $error("bridge level wrong");
   a_soft_zero: assert property ($rose(power_on) |-> duty == DUTY_ZERO ##1 duty <= DUTY_ONE)
      else $error("soft start not from zero");
   a_duty_pair: assert property ($past(duty) == DUTY_ZERO |-> !duty_drive_a && !duty_drive_b)
      else $error("duty pair active at zero duty");
   a_led_power: assert property (state == ST_REG |-> !led_n)
      else $error("led dark while powered");
   a_retry_fail: assert property (state == ST_EVAL && !sig_ok |=> state == ST_ZERO
      || state == ST_HOLD) else $error("failed detection did not repeat");

   c_regulating: cover property (state == ST_RAMP ##1 state == ST_REG);
   c_retry: cover property (state == ST_EVAL && !sig_ok);
   c_reset_powered: cover property (power_on ##1 state == ST_HOLD);

endmodule // pdr_top

// ### bench/pdr_far_side.sv
`timescale 1ns/1ps
module pdr_far_side
   import pdr_pkg::*;
(
   // clock
   input wire logic clk,
   // load condition set by the bench
   input wire logic pd_present,
   // drive pins from the block
   input wire logic switch_ctrl_n,
   input wire logic duty_drive_a,
   input wire logic duty_drive_b,
   // comparator pins
   output logic valid_signature_window,
   output logic output_voltage_sense
);
   logic [11:0] level = 12'h000;

   // with the switch closed the output node charges while a drive is high, leaks otherwise; with it open the node is cleared
   always_ff @(posedge clk) begin
      if (switch_ctrl_n) begin
         level <= 12'h000;
      end else if ((duty_drive_a || duty_drive_b) && level != 12'hfff) begin
         level <= level + 12'h001;
      end else if (level != 12'h000) begin
         level <= level - 12'h001;
      end
   end

   // set point comparator feeds the soft start loop
   assign output_voltage_sense = (level >= 12'h200);
   // bridge null only means something while the switch is open
   assign valid_signature_window = pd_present & switch_ctrl_n;
endmodule // pdr_far_side

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import pdr_pkg::*;
   // short counts keep the run brief
   localparam int ZC = 40;
   localparam int SC = 200;
   localparam int FC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic port_reset_n = 1'b0;
   logic pd_present = 1'b0;
   wire logic valid_signature_window;
   wire logic output_voltage_sense;
   wire logic switch_ctrl_n;
   wire logic duty_drive_a;
   wire logic duty_drive_b;
   wire logic switcher_ramp_clock;
   wire logic led_n;
   int errors = 0;
   int num_checks = 0;
   int sw, rc, da, db;

   always #20 clk = ~clk;

   pdr_top #(.ZERO_CYCLES(ZC), .STEP_CYCLES(SC), .SOFT_CYCLES(FC)) dut (
      .clk(clk), .rst(rst), .port_reset_n(port_reset_n),
      .valid_signature_window(valid_signature_window),
      .output_voltage_sense(output_voltage_sense),
      .switch_ctrl_n(switch_ctrl_n), .duty_drive_a(duty_drive_a),
      .duty_drive_b(duty_drive_b), .switcher_ramp_clock(switcher_ramp_clock),
      .led_n(led_n));

   pdr_far_side far (
      .clk(clk), .pd_present(pd_present), .switch_ctrl_n(switch_ctrl_n),
      .duty_drive_a(duty_drive_a), .duty_drive_b(duty_drive_b),
      .valid_signature_window(valid_signature_window),
      .output_voltage_sense(output_voltage_sense));

   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   // sample just after the edge so its updates have landed
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // count cycles with switch on, ramp high and each drive high
   task watch(input int n);
      sw = 0; rc = 0; da = 0; db = 0;
      repeat (n) begin
         cyc(1);
         sw += (switch_ctrl_n === 1'b0);
         rc += (switcher_ramp_clock === 1'b1);
         da += (duty_drive_a === 1'b1);
         db += (duty_drive_b === 1'b1);
      end
   endtask

   task summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // reset pin held low: port stays dark
   task t_pin_held();
      watch(30);
      check(sw, 0, "switch on under reset pin");
      check(rc + da + db, 0, "ramp or duty active under reset pin");
      check(led_n, 1'b1, "led lit under reset pin");
   endtask

   // no valid load: detection loops, converter never starts
   task t_no_load();
      @(posedge clk) port_reset_n <= 1'b1;
      watch(ZC);
      check(da + db, 0, "duty during zero hold");
      watch(3 * SC);
      check(da != 0 && db != 0, 1, "both drives stepped");
      check(sw + rc, 0, "converter on during steps");
      watch(ZC + 3 * SC + 60);
      check(sw + rc, 0, "converter on after failed pass");
   endtask

   // valid load: switch closes, ramp clock runs, duty soft starts
   task t_power_up();
      int n;
      int lo;
      int hi;
      @(posedge clk) pd_present <= 1'b1;
      n = 0;
      while (switch_ctrl_n !== 1'b0 && n < 3 * (ZC + 3 * SC)) begin
         cyc(1);
         n++;
      end
      check(switch_ctrl_n, 1'b0, "switch not closed");
      check({duty_drive_a, duty_drive_b}, 2'b00, "duty not zero at start");
      check(led_n, 1'b0, "led dark while powered");
      n = 0;
      while (switcher_ramp_clock !== 1'b0 && n < 200) begin
         cyc(1);
         n++;
      end
      lo = 0;
      while (switcher_ramp_clock === 1'b0 && lo < 200) begin
         cyc(1);
         lo++;
      end
      hi = 0;
      while (switcher_ramp_clock === 1'b1 && hi < 200) begin
         cyc(1);
         hi++;
      end
      check(lo, RAMP_HALF, "ramp low half");
      check(hi, RAMP_HALF, "ramp high half");
      // long enough for the soft start to reach the set point and hand over to regulation
      watch(1000);
      check(da != 0 && db != 0, 1, "duty never rose");
      check(sw, 1000, "switch dropped while powered");
      check(output_voltage_sense, 1'b1, "set point never reached");
   endtask

   // reset pin dropped while powered
   task t_pin_drop();
      @(posedge clk) port_reset_n <= 1'b0;
      cyc(1);
      check(switch_ctrl_n, 1'b0, "reset pin used before sync");
      cyc(6);
      watch(300);
      check(sw + rc + da + db, 0, "port active after reset pin");
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      t_pin_held();
      t_no_load();
      t_power_up();
      t_pin_drop();
      summarize();
   end

   // whole run is a few thousand cycles; allow ample margin
   initial begin
      #(20000 * 40);
      errors++;
      summarize();
   end
endmodule // testbench
